// *** common/fdbp_pkg.sv ***
// Package of constants and carrier types for the fieldbus data block packer
package fdbp_pkg;
	localparam int NBLK = 12;
	localparam int BLK_BYTES = 16;
	localparam int BASE_BYTES = 32;
	localparam int FBW = 4;
	localparam int NVAL = 18;
	localparam int BLKW = BLK_BYTES * 8;
	localparam int BUF_DEPTH = 2;
	localparam logic [7:0] START_BYTE0 = 8'h20;
	localparam logic [7:0] START_STEP = 8'h10;
	localparam int V_SUM = 0;
	localparam int V_DIFF = 1;
	localparam int V_OUT1 = 2;
	localparam int V_FA = 10;
	localparam int V_SA = 14;
	localparam logic [BLKW-1:0] BLK_ZERO = '0;

	typedef enum logic [4:0] {
		BT_NONE, BT_SUMDIFF, BT_OUT12, BT_OUT34, BT_OUT56, BT_OUT78,
		BT_FORCE_AB, BT_FORCE_CD, BT_SIG_AB, BT_SIG_CD, BT_LEVEL,
		BT_IN_STAT, BT_OUT_STAT, BT_IO_STAT, BT_AOUT14, BT_AOUT12, BT_AOUT34
	} fdbp_btype_t;

	typedef enum logic {FMT_FP, FMT_INT} fdbp_fmt_t;

	typedef struct packed {
		logic [31:0] fp;
		logic [31:0] ip;
		logic [15:0] dp;
	} fdbp_val_t;

	typedef struct packed {
		logic [FBW-1:0] idx;
		logic [31:0] err_fp;
		logic [31:0] stat_fp;
		logic [15:0] err_int;
		logic [15:0] stat_int;
		fdbp_val_t [NVAL-1:0] val;
	} fdbp_fb_t;

	typedef struct packed {
		logic [1:0][31:0] lvl_fp;
		logic [1:0][15:0] lvl_int;
		logic [2:0][31:0] in_fp;
		logic [2:0][31:0] out_fp;
		logic [2:0][15:0] in_int;
		logic [2:0][15:0] out_int;
		fdbp_val_t [3:0] aout;
	} fdbp_glob_t;

	typedef struct packed {
		fdbp_fb_t fb;
		fdbp_glob_t glob;
	} fdbp_upd_t;

	typedef struct packed {
		fdbp_btype_t btype;
		fdbp_fmt_t fmt;
		logic [FBW-1:0] fb_sel;
	} fdbp_cfg_t;

	typedef struct packed {
		logic [3:0] num;
		logic [7:0] start;
		fdbp_btype_t btype;
		fdbp_fmt_t fmt;
		logic [BLKW-1:0] data;
	} fdbp_blk_t;
endpackage : fdbp_pkg

// *** verilog/fdbp_buf.sv ***
// Two-entry buffer with valid and ready on both sides, head held in a flop
`timescale 1ns/1ps
module fdbp_buf #(
	parameter int W = 8
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [W-1:0] out_data,
	input wire logic out_ready
);
	logic [1:0] cnt_q;
	logic [1:0] cnt_d;
	logic [W-1:0] s1_q;
	logic push;
	logic pop;

	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb
	begin
		cnt_d = cnt_q;
		if (push && !pop)
			cnt_d = cnt_q + 2'd1;
		else if (pop && !push)
			cnt_d = cnt_q - 2'd1;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			cnt_q <= 2'd0;
			in_ready <= 1'b1;
			out_valid <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			in_ready <= (cnt_d != 2'd2);
			out_valid <= (cnt_d != 2'd0);
		end
	end

	// Head always in slot 0 so the output is a plain flop
	always_ff @(posedge clock)
	begin
		if (rst)
			out_data <= '0;
		else if (pop && cnt_q == 2'd2)
			out_data <= s1_q;
		else if (push && (cnt_q == 2'd0 || (pop && cnt_q == 2'd1)))
			out_data <= in_data;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			s1_q <= '0;
		else if (push && ((cnt_q == 2'd1 && !pop) || cnt_q == 2'd2))
			s1_q <= in_data;
	end

	a_no_overflow: assert property (@(posedge clock) disable iff (rst)
		cnt_q == 2'd2 && !out_ready |=> out_valid && !in_ready)
		else $error("buffer full state lost");
endmodule : fdbp_buf

// *** verilog/fdbp_packer.sv ***
// Packer that lays function block data into the configurable input image blocks
// Summary of operation
// - Twelve 16-byte blocks after the base block
// - Unused blocks are skipped, contents undefined
// - Byte positions count from block start byte
// - Source function block chosen per block
// - Float: error 0-3, status 4-7, MSB first
// - Integer: error 0-1, status 2-3, MSB first
// - Float sum block: sum at 8-11
// - Float sum block: difference at 12-15
// - Integer sum: int 4-7, dec 8-9
// - Integer difference: int 10-13, dec 14-15
// - Output pair reuses sum and difference layout
// - Integer second output: int 10-13, dec 14-15
// - Outputs 3/4, 5/6, 7/8 same layout
// - Float forces: A at 8-11, B at 12-15
// - Integer forces A and B split int/dec
// - Signal blocks for A/B and C/D, both formats
// - Level status and C/D forces, both formats
// - Split status float only, combined integer only
// - Analogue 1-4 float, two integer blocks
`timescale 1ns/1ps
module fdbp_packer #(
	parameter int NBLK = fdbp_pkg::NBLK
) (
	input wire logic clock,
	input wire logic rst,
	input wire fdbp_pkg::fdbp_cfg_t [NBLK-1:0] blk_cfg,
	input wire logic upd_valid,
	input wire fdbp_pkg::fdbp_upd_t upd,
	output logic upd_ready,
	output logic blk_valid,
	output fdbp_pkg::fdbp_blk_t blk,
	input wire logic blk_ready
);
	typedef enum logic {S_IDLE, S_SCAN} fdbp_state_t;

	fdbp_state_t st_q;
	fdbp_state_t st_d;
	logic [3:0] idx_q;
	logic [3:0] idx_d;
	fdbp_pkg::fdbp_upd_t upd_q;
	fdbp_pkg::fdbp_cfg_t cur_cfg;
	fdbp_pkg::fdbp_blk_t push_blk;
	logic want;
	logic buf_ready;
	logic push;
	logic accept;

	function automatic logic fdbp_is_fb(fdbp_pkg::fdbp_btype_t t);
		return t inside {fdbp_pkg::BT_SUMDIFF, fdbp_pkg::BT_OUT12, fdbp_pkg::BT_OUT34,
			fdbp_pkg::BT_OUT56, fdbp_pkg::BT_OUT78, fdbp_pkg::BT_FORCE_AB,
			fdbp_pkg::BT_FORCE_CD, fdbp_pkg::BT_SIG_AB, fdbp_pkg::BT_SIG_CD};
	endfunction : fdbp_is_fb

	// Illegal type and format pairs are dropped like unused blocks
	function automatic logic fdbp_wanted(fdbp_pkg::fdbp_cfg_t c, logic [3:0] fb);
		unique case (c.btype)
			fdbp_pkg::BT_NONE: return 1'b0;
			fdbp_pkg::BT_LEVEL: return 1'b1;
			fdbp_pkg::BT_IN_STAT, fdbp_pkg::BT_OUT_STAT, fdbp_pkg::BT_AOUT14:
				return c.fmt == fdbp_pkg::FMT_FP;
			fdbp_pkg::BT_IO_STAT, fdbp_pkg::BT_AOUT12, fdbp_pkg::BT_AOUT34:
				return c.fmt == fdbp_pkg::FMT_INT;
			default: return fdbp_is_fb(c.btype) && c.fb_sel == fb;
		endcase
	endfunction : fdbp_wanted

	// Common head plus two values, MSB first in each field
	function automatic logic [127:0] fdbp_pair(fdbp_pkg::fdbp_fmt_t f,
		fdbp_pkg::fdbp_fb_t s, fdbp_pkg::fdbp_val_t a, fdbp_pkg::fdbp_val_t b);
		if (f == fdbp_pkg::FMT_FP)
			return {s.err_fp, s.stat_fp, a.fp, b.fp};
		return {s.err_int, s.stat_int, a.ip, a.dp, b.ip, b.dp};
	endfunction : fdbp_pair

	function automatic int fdbp_first(fdbp_pkg::fdbp_btype_t t);
		unique case (t)
			fdbp_pkg::BT_OUT12: return fdbp_pkg::V_OUT1;
			fdbp_pkg::BT_OUT34: return fdbp_pkg::V_OUT1 + 2;
			fdbp_pkg::BT_OUT56: return fdbp_pkg::V_OUT1 + 4;
			fdbp_pkg::BT_OUT78: return fdbp_pkg::V_OUT1 + 6;
			fdbp_pkg::BT_FORCE_AB: return fdbp_pkg::V_FA;
			fdbp_pkg::BT_FORCE_CD: return fdbp_pkg::V_FA + 2;
			fdbp_pkg::BT_SIG_AB: return fdbp_pkg::V_SA;
			fdbp_pkg::BT_SIG_CD: return fdbp_pkg::V_SA + 2;
			default: return fdbp_pkg::V_SUM;
		endcase
	endfunction : fdbp_first

	function automatic logic [127:0] fdbp_layout(fdbp_pkg::fdbp_cfg_t c,
		fdbp_pkg::fdbp_upd_t u);
		int k;
		fdbp_pkg::fdbp_glob_t g;
		k = fdbp_first(c.btype);
		g = u.glob;
		if (fdbp_is_fb(c.btype))
			return fdbp_pair(c.fmt, u.fb, u.fb.val[k], u.fb.val[k+1]);
		unique case (c.btype)
			fdbp_pkg::BT_LEVEL:
				if (c.fmt == fdbp_pkg::FMT_FP)
					return {g.lvl_fp[0], g.lvl_fp[1], 64'h0000_0000_0000_0000};
				else
					return {g.lvl_int[0], g.lvl_int[1], 96'h0};
			fdbp_pkg::BT_IN_STAT: return {g.in_fp[0], g.in_fp[1], g.in_fp[2], 32'h0000_0000};
			fdbp_pkg::BT_OUT_STAT: return {g.out_fp[0], g.out_fp[1], g.out_fp[2], 32'h0000_0000};
			fdbp_pkg::BT_IO_STAT:
				return {g.in_int[0], g.in_int[1], g.in_int[2], 16'h0000,
					g.out_int[0], g.out_int[1], g.out_int[2], 16'h0000};
			fdbp_pkg::BT_AOUT14:
				return {g.aout[0].fp, g.aout[1].fp, g.aout[2].fp, g.aout[3].fp};
			fdbp_pkg::BT_AOUT12:
				return {g.aout[0].ip, g.aout[0].dp, g.aout[1].ip, g.aout[1].dp, 32'h0000_0000};
			fdbp_pkg::BT_AOUT34:
				return {g.aout[2].ip, g.aout[2].dp, g.aout[3].ip, g.aout[3].dp, 32'h0000_0000};
			default: return fdbp_pkg::BLK_ZERO;
		endcase
	endfunction : fdbp_layout

	function automatic logic [7:0] fdbp_start(logic [3:0] i);
		return fdbp_pkg::START_BYTE0 + 8'(i) * fdbp_pkg::START_STEP;
	endfunction : fdbp_start

	assign cur_cfg = blk_cfg[idx_q];
	assign want = fdbp_wanted(cur_cfg, upd_q.fb.idx);
	assign accept = upd_valid && upd_ready;
	assign push = st_q == S_SCAN && want && buf_ready;

	always_comb
	begin
		push_blk.num = idx_q;
		push_blk.start = fdbp_start(idx_q);
		push_blk.btype = cur_cfg.btype;
		push_blk.fmt = cur_cfg.fmt;
		push_blk.data = fdbp_layout(cur_cfg, upd_q);
	end

	always_comb
	begin
		st_d = st_q;
		idx_d = idx_q;
		unique case (st_q)
			S_IDLE:
				if (accept)
				begin
					st_d = S_SCAN;
					idx_d = 4'h0;
				end
			S_SCAN:
				// A stalled receiver holds the scan, so no block is dropped
				if (!want || buf_ready)
				begin
					if (idx_q == 4'(NBLK - 1))
						st_d = S_IDLE;
					else
						idx_d = idx_q + 4'h1;
				end
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			st_q <= S_IDLE;
			idx_q <= 4'h0;
			upd_ready <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			idx_q <= idx_d;
			upd_ready <= st_d == S_IDLE;
		end
	end

	// Snapshot is frozen for the whole scan so every block is coherent
	always_ff @(posedge clock)
	begin
		if (rst)
			upd_q <= '0;
		else if (accept)
			upd_q <= upd;
	end

	fdbp_buf #(
		.W($bits(fdbp_pkg::fdbp_blk_t))
	) u_buf (
		.clock(clock),
		.rst(rst),
		.in_valid(push),
		.in_data(push_blk),
		.in_ready(buf_ready),
		.out_valid(blk_valid),
		.out_data(blk),
		.out_ready(blk_ready)
	);

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	logic is_fb;
	logic is_fp;
	logic [127:0] d;
	assign is_fb = fdbp_is_fb(cur_cfg.btype);
	assign is_fp = cur_cfg.fmt == fdbp_pkg::FMT_FP;
	assign d = push_blk.data;
	fdbp_pkg::fdbp_fb_t fq;
	fdbp_pkg::fdbp_glob_t gq;
	fdbp_pkg::fdbp_btype_t bt;
	assign fq = upd_q.fb;
	assign gq = upd_q.glob;
	assign bt = cur_cfg.btype;

	sequence s_accept;
		upd_valid && upd_ready;
	endsequence

	sequence s_scan_start;
		st_q == S_SCAN && idx_q == 4'h0 && upd_q == $past(upd);
	endsequence

	// A scan visits every index, so it is busy for at least this long
	sequence s_scan_run;
		(st_q == S_SCAN && !upd_ready) [*8];
	endsequence

	a_start_addr: assert property (push |-> push_blk.start == 8'(32 + 16 * idx_q))
		else $error("block start byte wrong");
	a_unused_skip: assert property (bt == fdbp_pkg::BT_NONE |-> !push)
		else $error("unused block emitted");
	a_fb_select: assert property (push && is_fb |-> cur_cfg.fb_sel == fq.idx)
		else $error("wrong source function block");
	a_fp_head: assert property (push && is_fb && is_fp
		|-> d[127:64] == {fq.err_fp, fq.stat_fp})
		else $error("float head misplaced");
	a_int_head: assert property (push && is_fb && !is_fp
		|-> d[127:96] == {fq.err_int, fq.stat_int})
		else $error("integer head misplaced");
	a_fp_sumdiff: assert property (push && is_fp
		&& bt == fdbp_pkg::BT_SUMDIFF |-> d[63:0] == {fq.val[0].fp, fq.val[1].fp})
		else $error("float sum or difference misplaced");
	a_int_sumdiff: assert property (push && !is_fp
		&& bt == fdbp_pkg::BT_SUMDIFF
		|-> d[95:0] == {fq.val[0].ip, fq.val[0].dp, fq.val[1].ip, fq.val[1].dp})
		else $error("integer sum or difference misplaced");
	a_fp_out12: assert property (push && is_fp
		&& bt == fdbp_pkg::BT_OUT12 |-> d[63:0] == {fq.val[2].fp, fq.val[3].fp})
		else $error("float output pair misplaced");
	a_int_out12: assert property (push && !is_fp
		&& bt == fdbp_pkg::BT_OUT12
		|-> d[95:0] == {fq.val[2].ip, fq.val[2].dp, fq.val[3].ip, fq.val[3].dp})
		else $error("integer output pair misplaced");
	a_fp_out34: assert property (push && is_fp
		&& bt == fdbp_pkg::BT_OUT34 |-> d[63:0] == {fq.val[4].fp, fq.val[5].fp})
		else $error("float outputs three and four misplaced");
	a_out78_int: assert property (push && !is_fp
		&& bt == fdbp_pkg::BT_OUT78 |-> d[47:0] == {fq.val[9].ip, fq.val[9].dp})
		else $error("second output misplaced");
	a_force_fp: assert property (push && is_fp
		&& bt == fdbp_pkg::BT_FORCE_AB |-> d[63:0] == {fq.val[10].fp, fq.val[11].fp})
		else $error("float force misplaced");
	a_force_int: assert property (push && !is_fp
		&& bt == fdbp_pkg::BT_FORCE_AB
		|-> d[95:0] == {fq.val[10].ip, fq.val[10].dp, fq.val[11].ip, fq.val[11].dp})
		else $error("integer force misplaced");
	a_force_cd: assert property (push && !is_fp
		&& bt == fdbp_pkg::BT_FORCE_CD
		|-> d[95:0] == {fq.val[12].ip, fq.val[12].dp, fq.val[13].ip, fq.val[13].dp})
		else $error("integer force C or D misplaced");
	a_sig_ab: assert property (push && !is_fp
		&& bt == fdbp_pkg::BT_SIG_AB
		|-> d[95:0] == {fq.val[14].ip, fq.val[14].dp, fq.val[15].ip, fq.val[15].dp})
		else $error("integer signal A or B misplaced");
	a_sig_cd: assert property (push && is_fp
		&& bt == fdbp_pkg::BT_SIG_CD |-> d[63:0] == {fq.val[16].fp, fq.val[17].fp})
		else $error("signal C or D misplaced");
	a_level_fp: assert property (push && is_fp && bt == fdbp_pkg::BT_LEVEL
		|-> d == {gq.lvl_fp[0], gq.lvl_fp[1], 64'h0000_0000_0000_0000})
		else $error("float level status misplaced");
	a_level_int: assert property (push && !is_fp && bt == fdbp_pkg::BT_LEVEL
		|-> d == {gq.lvl_int[0], gq.lvl_int[1], 96'h0000_0000_0000_0000_0000_0000})
		else $error("integer level status misplaced");
	a_io_stat: assert property (push && bt == fdbp_pkg::BT_IO_STAT
		|-> d[127:80] == {gq.in_int[0], gq.in_int[1], gq.in_int[2]}
		&& d[63:16] == {gq.out_int[0], gq.out_int[1], gq.out_int[2]})
		else $error("combined status misplaced");
	a_split_stat: assert property (bt == fdbp_pkg::BT_IN_STAT && !is_fp
		|-> !push)
		else $error("integer split status emitted");
	a_aout_fp: assert property (push && bt == fdbp_pkg::BT_AOUT14
		|-> d == {gq.aout[0].fp, gq.aout[1].fp, gq.aout[2].fp, gq.aout[3].fp})
		else $error("float analogue block misplaced");
	a_aout_int: assert property (bt == fdbp_pkg::BT_AOUT12 && is_fp
		|-> !push)
		else $error("float split analogue emitted");
	a_scan_snap: assert property (s_accept |=> s_scan_start)
		else $error("scan did not start on captured update");
	a_scan_stable: assert property (st_q == S_SCAN |=> $stable(upd_q))
		else $error("snapshot changed mid scan");
	a_scan_busy: assert property (st_q == S_SCAN |-> !upd_ready)
		else $error("update offered mid scan");
	a_scan_min: assert property (s_accept |=> s_scan_run)
		else $error("scan ended too early");
	a_blk_hold: assert property (blk_valid && !blk_ready
		|=> blk_valid && $stable(blk))
		else $error("stalled block lost");
endmodule : fdbp_packer

// *** test/fdbp_sink.sv ***
// Fieldbus master model that takes packed blocks, stalling on request
`timescale 1ns/1ps
module fdbp_sink (
	input wire logic clock,
	input wire logic rst,
	input wire logic blk_valid,
	input wire fdbp_pkg::fdbp_blk_t blk,
	output logic blk_ready,
	input wire logic stall
);
	fdbp_pkg::fdbp_blk_t q[$];
	logic [1:0] ph_q = 2'h0;

	initial blk_ready = 1'b0;

	// Slow mode takes one cycle in four, so the buffer fills and the scan stalls
	always @(negedge clock)
	begin
		ph_q <= ph_q + 2'h1;
		blk_ready <= !rst && (!stall || ph_q == 2'h3);
	end

	always @(posedge clock)
	begin
		if (!rst && blk_valid && blk_ready)
			q.push_back(blk);
	end
endmodule : fdbp_sink

// *** test/fdbp_packer_bench.sv ***
// Self-checking testbench for the fieldbus data block packer
`timescale 1ns/1ps
module fdbp_packer_bench;
	logic clock;
	logic rst;
	fdbp_pkg::fdbp_cfg_t [11:0] blk_cfg;
	logic upd_valid;
	fdbp_pkg::fdbp_upd_t upd;
	logic upd_ready;
	logic blk_valid;
	fdbp_pkg::fdbp_blk_t blk;
	logic blk_ready;
	logic stall;
	int n_errors = 0;
	int n_checks = 0;

	fdbp_packer i_dut (.clock(clock), .rst(rst), .blk_cfg(blk_cfg), .upd_valid(upd_valid),
		.upd(upd), .upd_ready(upd_ready), .blk_valid(blk_valid), .blk(blk),
		.blk_ready(blk_ready));
	fdbp_sink i_sink (.clock(clock), .rst(rst), .blk_valid(blk_valid), .blk(blk),
		.blk_ready(blk_ready), .stall(stall));

	task automatic test_done;
		if (n_errors == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : test_done

	task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
		n_checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	function automatic bit want_f(fdbp_pkg::fdbp_cfg_t c, fdbp_pkg::fdbp_upd_t u);
		case (c.btype)
			fdbp_pkg::BT_NONE: return 1'b0;
			fdbp_pkg::BT_LEVEL: return 1'b1;
			fdbp_pkg::BT_IN_STAT, fdbp_pkg::BT_OUT_STAT, fdbp_pkg::BT_AOUT14:
				return c.fmt == fdbp_pkg::FMT_FP;
			fdbp_pkg::BT_IO_STAT, fdbp_pkg::BT_AOUT12, fdbp_pkg::BT_AOUT34:
				return c.fmt == fdbp_pkg::FMT_INT;
			default: return c.fb_sel == u.fb.idx;
		endcase
	endfunction : want_f

	function automatic logic [127:0] exp_f(fdbp_pkg::fdbp_cfg_t c, fdbp_pkg::fdbp_upd_t u);
		fdbp_pkg::fdbp_fb_t f;
		fdbp_pkg::fdbp_glob_t g;
		fdbp_pkg::fdbp_val_t a;
		fdbp_pkg::fdbp_val_t b;
		int k;
		f = u.fb;
		g = u.glob;
		k = 2 * (int'(c.btype) - 1);
		if (k < 0 || k > 16)
			k = 0;
		a = f.val[k];
		b = f.val[k + 1];
		case (c.btype)
			fdbp_pkg::BT_LEVEL: return (c.fmt == fdbp_pkg::FMT_FP) ?
				{g.lvl_fp[0], g.lvl_fp[1], 64'h0} : {g.lvl_int[0], g.lvl_int[1], 96'h0};
			fdbp_pkg::BT_IN_STAT: return {g.in_fp[0], g.in_fp[1], g.in_fp[2], 32'h0};
			fdbp_pkg::BT_OUT_STAT: return {g.out_fp[0], g.out_fp[1], g.out_fp[2], 32'h0};
			fdbp_pkg::BT_IO_STAT: return {g.in_int[0], g.in_int[1], g.in_int[2], 16'h0,
				g.out_int[0], g.out_int[1], g.out_int[2], 16'h0};
			fdbp_pkg::BT_AOUT14: return {g.aout[0].fp, g.aout[1].fp, g.aout[2].fp, g.aout[3].fp};
			fdbp_pkg::BT_AOUT12: return {g.aout[0].ip, g.aout[0].dp, g.aout[1].ip,
				g.aout[1].dp, 32'h0};
			fdbp_pkg::BT_AOUT34: return {g.aout[2].ip, g.aout[2].dp, g.aout[3].ip,
				g.aout[3].dp, 32'h0};
			default: return (c.fmt == fdbp_pkg::FMT_FP) ? {f.err_fp, f.stat_fp, a.fp, b.fp} :
				{f.err_int, f.stat_int, a.ip, a.dp, b.ip, b.dp};
		endcase
	endfunction : exp_f

	// One update through a full scan; the live input is spoiled after the take
	task automatic scan(input int t[12], input fdbp_pkg::fdbp_fmt_t fmt, input int idx,
		input int bad, input int s, input logic slow);
		fdbp_pkg::fdbp_upd_t u;
		fdbp_pkg::fdbp_blk_t b;
		int w;
		for (int i = 0; i < $bits(u); i++)
			u[i] = ((i * 13 + s) % 7) < 3;
		u.fb.idx = idx[3:0];
		@(negedge clock);
		for (int i = 0; i < 12; i++)
			blk_cfg[i] = '{fdbp_pkg::fdbp_btype_t'(t[i]), fmt,
				(i == bad) ? idx[3:0] + 4'h1 : idx[3:0]};
		upd = u;
		upd_valid = 1'b1;
		stall = slow;
		w = 0;
		while (upd_ready !== 1'b1 && w < 100)
		begin
			@(negedge clock);
			w++;
		end
		chk("take", 128'h1, {127'h0, w < 100});
		// Taken at the rising edge just passed; dropping valid now avoids a second take
		@(negedge clock);
		upd_valid = 1'b0;
		upd = ~u;
		w = 0;
		do @(negedge clock); while (!(upd_ready === 1'b1 && blk_valid === 1'b0) && ++w < 300);
		chk("scan_end", 128'h1, {127'h0, w < 300});
		for (int i = 0; i < 12; i++)
			if (want_f(blk_cfg[i], u))
			begin
				b = (i_sink.q.size() > 0) ? i_sink.q.pop_front() : '0;
				chk("num", i, b.num);
				chk("kind", {blk_cfg[i].btype, blk_cfg[i].fmt}, {b.btype, b.fmt});
				chk("start", 32 + 16 * i, b.start);
				chk("data", exp_f(blk_cfg[i], u), b.data);
			end
		chk("extra", 128'h0, i_sink.q.size());
	endtask : scan

	initial
	begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	initial
	begin
		#200000;
		n_errors++;
		test_done;
	end

	initial
	begin
		rst = 1'b1;
		upd_valid = 1'b0;
		upd = '0;
		blk_cfg = '0;
		stall = 1'b0;
		repeat (20) @(posedge clock);
		@(negedge clock);
		rst = 1'b0;
		@(posedge clock);
		@(negedge clock);
		chk("ready", 128'h1, upd_ready);
		chk("valid", 128'h0, blk_valid);
		scan('{1, 2, 3, 4, 5, 6, 7, 8, 10, 11, 12, 14}, fdbp_pkg::FMT_FP, 5, -1, 1,
			1'b0);
		scan('{1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 13, 15}, fdbp_pkg::FMT_INT, 15, -1, 2,
			1'b1);
		scan('{0, 11, 12, 14, 16, 1, 0, 9, 0, 10, 0, 0}, fdbp_pkg::FMT_INT, 0, 5, 3,
			1'b1);
		scan('{9, 13, 15, 16, 9, 1, 0, 0, 0, 0, 0, 0}, fdbp_pkg::FMT_FP, 7, 4, 4,
			1'b0);
		test_done;
	end
endmodule : fdbp_packer_bench
